// File: rtl/slc_codec.sv
// Purpose: serial link codec, transmit and receive ends behind an AHB-Lite port
// Assumes: hclk is the bit clock, so one symbol spans 10, 11 or 12 hclk cycles
// Notes: byte clock falls at mid-symbol; outputs of the link side are registered
// What this block does
// - sync symbols are never sent on request, only as idle padding
// - a strobe with all command bits zero sends the data symbol
// - symbol lasts ten, eleven or twelve bit times by mode
// - in local mode the transmit clock output copies the reference
// - strobe with both stages empty loads stage two and raises ack
// - stage two moves to the encoder latch at byte clock fall
// - stage one loads only while stage two busy; later strobes overwrite
// - at byte clock fall stage one moves to stage two; local ack rises
// - encoder emits data or command symbol of 10, 11 or 12 bits
// - shifter loads pending symbol at boundary, else shifts in sync serially
// - serial output sends the msb of the symbol first
// - receiver finding sync restarts its boundary counter
// - receive clock output marks received byte boundaries
// - outputs update on boundary, cascade fall or sync
// - warning falls on half sync or cascade low, rises on half data
// - warning is high during the byte before new outputs
// - decoder yields 8/4, 9/3 or 10/2 data or command bits
// - data updates only data outputs, commands only command outputs
// - idle sync symbols keep producing command strobes
// - invalid symbols are flagged and still fire one strobe
module slc_codec
  import slc_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // serial link
  output logic serial_out_pos,
  output logic serial_out_neg,
  input wire logic serial_in_pos,
  input wire logic serial_in_neg,
  // clocks and straps
  input wire logic ref_osc_in,
  input wire logic width_select,
  input wire logic test_local_select,
  output logic tx_clk_out,
  output logic rx_clk_out,
  // receive handshake
  input wire logic cascade_hold_in,
  output logic early_word_warning,
  output logic rx_word_strobe,
  output logic rx_cmd_strobe
);
  // synchronisers
  logic [PIN_N-1:0] pin_a_q;
  logic [PIN_N-1:0] pin_b_q;
  logic local_mode;
  slc_mode_t mode;
  logic [3:0] len;
  logic [3:0] hlen;
  logic [SYM_W-1:0] sync_w;
  logic [SYM_W-1:0] lmask;
  logic [SYM_W-1:0] hmask;

  // bus state
  logic ph_v_q, ph_v_d;
  logic ph_w_q, ph_w_d;
  logic [7:0] ph_a_q, ph_a_d;
  logic [31:0] rd_q, rd_d;
  logic ten_q, ten_d;
  logic acc;
  logic wr_ok;
  logic wr_tx;
  logic clr_viol;

  // transmit state
  logic [3:0] tcnt_q, tcnt_d;
  logic [WORD_W-1:0] s1_q, s1_d;
  logic [WORD_W-1:0] s2_q, s2_d;
  logic s1v_q, s1v_d;
  logic s2v_q, s2v_d;
  logic [SYM_W-1:0] enc_q, enc_d;
  logic encv_q, encv_d;
  logic ack_q, ack_d;
  logic [SYM_W-1:0] tsh_q, tsh_d;
  logic serp_q, serp_d;
  logic sern_q, sern_d;
  logic tclk_q, tclk_d;
  logic tx_half;
  logic tx_bnd;

  // receive state
  logic [3:0] rcnt_q, rcnt_d;
  logic [SYM_W-1:0] rsh_q, rsh_d;
  logic [SYM_W-1:0] dsym_q, dsym_d;
  logic dnew_q, dnew_d;
  logic casc_old_q, casc_old_d;
  logic [DAT_W-1:0] rxd_q, rxd_d;
  logic [CMD_W-1:0] rxc_q, rxc_d;
  logic wstb_q, wstb_d;
  logic cstb_q, cstb_d;
  logic viol_q, viol_d;
  logic warn_q, warn_d;
  logic rclk_q, rclk_d;
  logic rx_bit;
  logic sync_hit;
  logic half_sync;
  logic rbnd;
  logic upd;
  slc_dec_t dec;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_a_q <= '0;
      pin_b_q <= '0;
    end
    else
    begin
      pin_a_q <= {test_local_select, width_select, ref_osc_in, cascade_hold_in, serial_in_neg, serial_in_pos};
      pin_b_q <= pin_a_q;
    end
  end

  always_comb
  begin
    local_mode = !pin_b_q[P_TLS];
    // control bit overrides the strap to reach 10-bit mode
    mode = ten_q ? MODE10 : (pin_b_q[P_WSEL] ? MODE9 : MODE8);
    len = sym_len(mode);
    hlen = half_len(mode);
    sync_w = sync_code(mode);
    lmask = len_mask(len);
    hmask = len_mask(hlen);
  end

  // bus: zero wait states, read data captured in the address phase
  always_comb
  begin
    acc = hsel && hready && htrans[1] && (hsize == HSIZE_WORD);
    ph_v_d = acc;
    ph_w_d = hwrite;
    ph_a_d = haddr[7:0];
    rd_d = '0;
    if (acc && !hwrite)
    begin
      if (haddr[7:0] == A_CTRL)
        rd_d = {31'h0, ten_q};
      else if (haddr[7:0] == A_STAT)
        rd_d = {24'h0, mode, s1v_q, s2v_q, ack_q, warn_q, viol_q};
      else if (haddr[7:0] == A_RXD)
        rd_d = {22'h0, rxd_q};
      else if (haddr[7:0] == A_RXC)
        rd_d = {28'h0, rxc_q};
    end
    wr_ok = ph_v_q && ph_w_q;
    wr_tx = wr_ok && (ph_a_q == A_TXW);
    clr_viol = wr_ok && (ph_a_q == A_STAT) && hwdata[ST_VIOL];
    ten_d = (wr_ok && (ph_a_q == A_CTRL)) ? hwdata[0] : ten_q;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ph_v_q <= 1'b0;
      ph_w_q <= 1'b0;
      ph_a_q <= '0;
      rd_q <= '0;
      ten_q <= 1'b0;
    end
    else
    begin
      ph_v_q <= ph_v_d;
      ph_w_q <= ph_w_d;
      ph_a_q <= ph_a_d;
      rd_q <= rd_d;
      ten_q <= ten_d;
    end
  end

  // transmit: byte clock is high for the first half of each symbol
  always_comb
  begin
    tx_half = (tcnt_q == hlen - 4'h1);
    tx_bnd = (tcnt_q >= len - 4'h1);
    tcnt_d = tx_bnd ? 4'h0 : tcnt_q + 4'h1;
    s1_d = s1_q;
    s1v_d = s1v_q;
    s2_d = s2_q;
    s2v_d = s2v_q;
    enc_d = enc_q;
    encv_d = encv_q;
    ack_d = ack_q;
    // sync is fed bit by bit so an idle shifter holds a whole sync symbol
    tsh_d = {tsh_q[SYM_W-2:0], sync_w[len - 4'h1 - tcnt_q]};
    if (tx_half)
    begin
      enc_d = encode(mode, s2_q[DAT_W-1:0], s2_q[WORD_W-1:DAT_W]);
      encv_d = s2v_q;
      s2_d = s1_q;
      s2v_d = s1v_q;
      s1v_d = 1'b0;
      if (local_mode)
        ack_d = 1'b1;
    end
    if (wr_tx)
    begin
      if (!s2v_d)
      begin
        s2_d = {hwdata[TXW_CMD_LSB +: CMD_W], hwdata[DAT_W-1:0]};
        s2v_d = 1'b1;
        ack_d = 1'b1;
      end
      else
      begin
        // no protection: a further write in this byte replaces stage one
        s1_d = {hwdata[TXW_CMD_LSB +: CMD_W], hwdata[DAT_W-1:0]};
        s1v_d = 1'b1;
        ack_d = 1'b0;
      end
    end
    if (tx_bnd && encv_q)
    begin
      tsh_d = enc_q;
      encv_d = 1'b0;
    end
    serp_d = tsh_q[len - 4'h1];
    sern_d = !tsh_q[len - 4'h1];
    tclk_d = local_mode ? pin_b_q[P_REF] : (tcnt_q < hlen);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tcnt_q <= '0;
      s1_q <= '0;
      s2_q <= '0;
      s1v_q <= 1'b0;
      s2v_q <= 1'b0;
      enc_q <= '0;
      encv_q <= 1'b0;
      ack_q <= 1'b0;
      tsh_q <= '0;
      serp_q <= 1'b0;
      sern_q <= 1'b1;
      tclk_q <= 1'b0;
    end
    else
    begin
      tcnt_q <= tcnt_d;
      s1_q <= s1_d;
      s2_q <= s2_d;
      s1v_q <= s1v_d;
      s2v_q <= s2v_d;
      enc_q <= enc_d;
      encv_q <= encv_d;
      ack_q <= ack_d;
      tsh_q <= tsh_d;
      serp_q <= serp_d;
      sern_q <= sern_d;
      tclk_q <= tclk_d;
    end
  end

  // receive
  always_comb
  begin
    rx_bit = pin_b_q[P_POS] && !pin_b_q[P_NEG];
    rsh_d = {rsh_q[SYM_W-2:0], rx_bit};
    sync_hit = ((rsh_d & lmask) == sync_w);
    rbnd = sync_hit || (rcnt_q >= len - 4'h1);
    rcnt_d = rbnd ? 4'h0 : rcnt_q + 4'h1;
    dsym_d = rbnd ? (rsh_d & lmask) : dsym_q;
    dnew_d = rbnd;
    casc_old_d = pin_b_q[P_CASC];
    dec = decode(mode, dsym_q);
    // a cascade fall re-presents the last decoded symbol
    upd = dnew_q || (casc_old_q && !pin_b_q[P_CASC]);
    wstb_d = upd && !dec.is_cmd;
    cstb_d = upd && dec.is_cmd;
    rxd_d = (upd && !dec.is_cmd) ? dec.data : rxd_q;
    rxc_d = (upd && dec.is_cmd) ? dec.cmd : rxc_q;
    viol_d = (upd && dec.viol) || (viol_q && !clr_viol);
    half_sync = (((rsh_d ^ (sync_w >> (len - hlen))) & hmask) == '0);
    warn_d = warn_q;
    if (!pin_b_q[P_CASC])
      warn_d = 1'b0;
    else if (rcnt_q == hlen - 4'h1)
      warn_d = !half_sync;
    rclk_d = (rcnt_d < hlen);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rcnt_q <= '0;
      rsh_q <= '0;
      dsym_q <= '0;
      dnew_q <= 1'b0;
      casc_old_q <= 1'b0;
      rxd_q <= '0;
      rxc_q <= '0;
      wstb_q <= 1'b0;
      cstb_q <= 1'b0;
      viol_q <= 1'b0;
      warn_q <= 1'b0;
      rclk_q <= 1'b0;
    end
    else
    begin
      rcnt_q <= rcnt_d;
      rsh_q <= rsh_d;
      dsym_q <= dsym_d;
      dnew_q <= dnew_d;
      casc_old_q <= casc_old_d;
      rxd_q <= rxd_d;
      rxc_q <= rxc_d;
      wstb_q <= wstb_d;
      cstb_q <= cstb_d;
      viol_q <= viol_d;
      warn_q <= warn_d;
      rclk_q <= rclk_d;
    end
  end

  assign hrdata = rd_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign serial_out_pos = serp_q;
  assign serial_out_neg = sern_q;
  assign tx_clk_out = tclk_q;
  assign rx_clk_out = rclk_q;
  assign early_word_warning = warn_q;
  assign rx_word_strobe = wstb_q;
  assign rx_cmd_strobe = cstb_q;
endmodule // slc_codec

// File: shared/slc_pkg.sv
// Purpose: constants, symbol tables and coding functions of the serial link codec
// Assumes: symbols are right-aligned in a 12-bit field, msb sent first
// Notes: register offsets are byte addresses on the AHB-Lite port
package slc_pkg;
  typedef enum logic [2:0] {MODE8 = 3'b001, MODE9 = 3'b010, MODE10 = 3'b100} slc_mode_t;
  localparam int unsigned SYM_W = 12;
  localparam int unsigned DAT_W = 10;
  localparam int unsigned CMD_W = 4;
  localparam int unsigned WORD_W = DAT_W + CMD_W;
  localparam logic [3:0] LEN8 = 4'hA;
  localparam logic [3:0] LEN9 = 4'hB;
  localparam logic [3:0] LEN10 = 4'hC;
  localparam logic [3:0] HALF8 = 4'h5;
  localparam logic [3:0] HALF_WIDE = 4'h6;
  // register map
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_TXW = 8'h04;
  localparam logic [7:0] A_RXD = 8'h08;
  localparam logic [7:0] A_RXC = 8'h0C;
  localparam logic [7:0] A_STAT = 8'h10;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam int unsigned TXW_CMD_LSB = 12;
  localparam int unsigned ST_VIOL = 0;
  // synchroniser slots
  localparam int unsigned P_POS = 0;
  localparam int unsigned P_NEG = 1;
  localparam int unsigned P_CASC = 2;
  localparam int unsigned P_REF = 3;
  localparam int unsigned P_WSEL = 4;
  localparam int unsigned P_TLS = 5;
  localparam int unsigned PIN_N = 6;
  localparam logic [SYM_W-1:0] SYNC8 = 12'h311;
  localparam logic [SYM_W-1:0] SYNC9 = 12'h311;
  localparam logic [SYM_W-1:0] SYNC10 = 12'h623;
  localparam logic [4:0] NIB5 [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
                                       5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
  // entry 0 of each table is the sync symbol
  localparam logic [SYM_W-1:0] CMD8 [16] = '{SYNC8, 12'h3FF, 12'h1AD, 12'h1B9, 12'h3E4, 12'h1A7,
    12'h327, 12'h339, 12'h084, 12'h09F, 12'h080, 12'h0E7, 12'h0F9, 12'h004, 12'h01F, 12'h000};
  localparam logic [SYM_W-1:0] CMD9 [8] = '{SYNC9, 12'h7FF, 12'h3AD, 12'h3B9, 12'h7E4, 12'h3A7,
    12'h727, 12'h739};
  localparam logic [SYM_W-1:0] CMD10 [4] = '{SYNC10, 12'hFFF, 12'h75D, 12'h779};

  typedef struct packed {
    logic viol;
    logic is_cmd;
    logic [CMD_W-1:0] cmd;
    logic [DAT_W-1:0] data;
  } slc_dec_t;

  function automatic logic [3:0] sym_len(slc_mode_t m);
    sym_len = (m == MODE10) ? LEN10 : (m == MODE9) ? LEN9 : LEN8;
  endfunction

  function automatic logic [3:0] half_len(slc_mode_t m);
    half_len = (m == MODE8) ? HALF8 : HALF_WIDE;
  endfunction

  function automatic logic [SYM_W-1:0] sync_code(slc_mode_t m);
    sync_code = (m == MODE10) ? SYNC10 : (m == MODE9) ? SYNC9 : SYNC8;
  endfunction

  function automatic logic [SYM_W-1:0] len_mask(logic [3:0] n);
    logic [SYM_W:0] t;
    t = ({{SYM_W{1'b0}}, 1'b1} << n) - {{SYM_W{1'b0}}, 1'b1};
    len_mask = t[SYM_W-1:0];
  endfunction

  // bit 4 flags a valid group
  function automatic logic [4:0] dec5(logic [4:0] g);
    dec5 = 5'h00;
    for (int i = 0; i < 16; i++)
      if (NIB5[i] == g)
        dec5 = {1'b1, 4'(i)};
  endfunction

  function automatic logic [SYM_W-1:0] encode(slc_mode_t m, logic [DAT_W-1:0] d, logic [CMD_W-1:0] c);
    case (m)
      MODE9: encode = (c[2:0] == 3'h0) ? {1'b0, d[8], NIB5[d[7:4]], NIB5[d[3:0]]} : CMD9[c[2:0]];
      MODE10: encode = (c[1:0] == 2'h0) ? {d[8], NIB5[d[7:4]], d[9], NIB5[d[3:0]]} : CMD10[c[1:0]];
      default: encode = (c == 4'h0) ? {2'h0, NIB5[d[7:4]], NIB5[d[3:0]]} : CMD8[c];
    endcase
  endfunction

  // commands take priority over data groups
  function automatic slc_dec_t decode(slc_mode_t m, logic [SYM_W-1:0] s);
    logic [4:0] h;
    logic [4:0] l;
    decode = '0;
    h = dec5((m == MODE10) ? s[10:6] : s[9:5]);
    l = dec5(s[4:0]);
    case (m)
      MODE9: decode.data = {1'b0, s[10], h[3:0], l[3:0]};
      MODE10: decode.data = {s[5], s[11], h[3:0], l[3:0]};
      default: decode.data = {2'h0, h[3:0], l[3:0]};
    endcase
    decode.viol = !(h[4] && l[4]);
    for (int i = 0; i < 16; i++)
      if (m == MODE8 && s == CMD8[i])
        decode = '{1'b0, 1'b1, 4'(i), decode.data};
    for (int i = 0; i < 8; i++)
      if (m == MODE9 && s == CMD9[i])
        decode = '{1'b0, 1'b1, 4'(i), decode.data};
    for (int i = 0; i < 4; i++)
      if (m == MODE10 && s == CMD10[i])
        decode = '{1'b0, 1'b1, 4'(i), decode.data};
  endfunction
endpackage

// File: tb/slc_monitor.sv
// Purpose: port checker of the serial link codec
// Assumes: link looped back by the partner, local mode
// Notes: counters give the idle and warning ages
module slc_monitor (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  // link and pins
  input wire logic ref_osc_in,
  input wire logic test_local_select,
  input wire logic serial_out_pos,
  input wire logic serial_out_neg,
  input wire logic cascade_hold_in,
  input wire logic early_word_warning,
  input wire logic rx_word_strobe,
  input wire logic rx_cmd_strobe,
  input wire logic tx_clk_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] quiet_q, quiet_d;
  logic [5:0] gap_q, gap_d;
  always_comb
  begin
    quiet_d = (quiet_q == 8'hFF) ? quiet_q : quiet_q + 8'h01;
    if (hsel && hready && htrans[1] && hwrite)
      quiet_d = 8'h00;
    gap_d = (gap_q == 6'h3F) ? gap_q : gap_q + 6'h01;
    if (early_word_warning)
      gap_d = 6'h00;
  end
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      quiet_q <= 8'h00;
      gap_q <= 6'h3F;
    end
    else
    begin
      quiet_q <= quiet_d;
      gap_q <= gap_d;
    end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_casc_low;
    !cascade_hold_in [*4];
  endsequence
  sequence s_any_stb;
    ##[1:8] (rx_word_strobe || rx_cmd_strobe);
  endsequence
  AST_LINE_DIFF: assert property (serial_out_neg == !serial_out_pos)
    else $error("line outputs not complementary");
  AST_STB_EXCL: assert property (!(rx_word_strobe && rx_cmd_strobe))
    else $error("both strobes at once");
  AST_WARN_LOW: assert property (s_casc_low |-> !early_word_warning)
    else $error("warning high while cascade low");
  AST_CASC_FALL: assert property ($fell(cascade_hold_in) |-> s_any_stb)
    else $error("no strobe after cascade fall");
  // two sync flops and the output flop put the copy three edges behind
  AST_TXCLK_COPY: assert property ($past(hresetn, 5) && !test_local_select |-> tx_clk_out == $past(ref_osc_in, 3))
    else $error("clock output not the reference");
  AST_IDLE_CMD: assert property (quiet_q == 8'hFF && cascade_hold_in |-> ##[0:12] rx_cmd_strobe)
    else $error("idle line gives no command strobe");
  AST_WARN_FIRST: assert property (rx_word_strobe && cascade_hold_in && $past(cascade_hold_in, 8)
    |-> gap_q < 6'h18)
    else $error("data without early warning");
  AST_IDLE_SYNC: assert property (quiet_q == 8'hFF |-> serial_out_pos == $past(serial_out_pos, 10)
    || serial_out_pos == $past(serial_out_pos, 11) || serial_out_pos == $past(serial_out_pos, 12))
    else $error("idle line not repeating");
endmodule // slc_monitor
bind slc_codec slc_monitor u_mon (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .ref_osc_in,
  .test_local_select, .serial_out_pos, .serial_out_neg, .cascade_hold_in, .early_word_warning,
  .rx_word_strobe, .rx_cmd_strobe, .tx_clk_out);

// File: tb/slc_link_model.sv
// Purpose: far end of the serial link, loops the line back
// Assumes: one bit per hclk
// Notes: jam sends a group that is neither data nor command
module slc_link_model (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // line in, fault request, line out
  input wire logic line_pos,
  input wire logic line_neg,
  input wire logic jam,
  output logic ret_pos,
  output logic ret_neg
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] pat_q;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      ret_pos <= 1'b0;
      ret_neg <= 1'b1;
      pat_q <= 5'h06;
    end
    else
    begin
      pat_q <= {pat_q[3:0], pat_q[4]};
      ret_pos <= jam ? pat_q[4] : line_pos & ~line_neg;
      ret_neg <= jam ? ~pat_q[4] : ~(line_pos & ~line_neg);
    end
endmodule // slc_link_model

// File: tb/testbench.sv
// Purpose: self-checking bench of the serial link codec
// Assumes: loop-back partner, local mode tied
// Notes: xorshift stimulus seeded at 23
module testbench
  import slc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = HSIZE_WORD;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, sop, son, sip, sin, txc, rxc, warn, wstb_o, cstb_o;
  logic ref_osc_in = 1'b0;
  logic width_select = 1'b0;
  logic cascade_hold_in = 1'b1;
  logic jam = 1'b0;
  logic [31:0] rnd = 32'h17;
  logic [9:0] d, w0, w2;
  slc_mode_t m;
  int n_mismatch = 0;
  int check_count = 0;
  int n_rxh = 0;
  int n_txh = 0;
  always #4 hclk = ~hclk;
  always @(posedge hclk) ref_osc_in <= ~ref_osc_in;
  slc_codec u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .serial_out_pos(sop), .serial_out_neg(son), .serial_in_pos(sip),
    .serial_in_neg(sin), .ref_osc_in, .width_select, .test_local_select(1'b0), .tx_clk_out(txc),
    .rx_clk_out(rxc), .cascade_hold_in, .early_word_warning(warn), .rx_word_strobe(wstb_o),
    .rx_cmd_strobe(cstb_o));
  slc_link_model u_link (.hclk, .hresetn, .line_pos(sop), .line_neg(son), .jam, .ret_pos(sip), .ret_neg(sin));
  function automatic logic [31:0] xs(logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [9:0] dmask(slc_mode_t md);
    return (md == MODE10) ? 10'h3FF : (md == MODE9) ? 10'h1FF : 10'h0FF;
  endfunction
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic fail();
    n_mismatch++;
    $display("MISMATCH %0t wait ran out", $time);
    conclude();
  endtask
  task automatic rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 50)
        fail();
      @(posedge hclk);
    end
  endtask
  // one whole-word transfer; hold everything until hready
  task automatic bus(logic [7:0] a, logic w, logic [31:0] wd);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    hsel <= 1'b1;
    rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    rdy();
    rd = hrdata;
  endtask
  task automatic wstb(logic c);
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
      if (n > 400)
        fail();
    end
    while ((c ? cstb_o : wstb_o) !== 1'b1);
  endtask
  // idle sync strobes come between, so skip command zero
  task automatic getcmd(logic [3:0] c);
    for (int i = 0; i < 6; i++)
    begin
      wstb(1'b1);
      bus(A_RXC, 1'b0, 32'h0);
      if (rd[3:0] === c)
        break;
    end
    chk(rd, {28'h0, c});
  endtask
  initial
  begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    for (int k = 0; k < 3; k++)
    begin
      m = (k == 0) ? MODE8 : (k == 1) ? MODE9 : MODE10;
      width_select <= (k == 1);
      bus(A_CTRL, 1'b1, {31'h0, k == 2});
      repeat (80) @(posedge hclk);
      bus(A_STAT, 1'b0, 32'h0);
      chk(rd[7:5], m);
      wstb(1'b1);
      bus(A_RXC, 1'b0, 32'h0);
      chk(rd, 32'h0);
      for (int i = 0; i < 6; i++)
      begin
        rnd = xs(rnd);
        d = (i == 0) ? dmask(m) : (i == 1) ? 10'h0 : rnd[9:0] & dmask(m);
        bus(A_TXW, 1'b1, {22'h0, d});
        wstb(1'b0);
        bus(A_RXD, 1'b0, 32'h0);
        chk(rd, {22'h0, d});
      end
      // each command once, never a long run of one code
      for (int c = 1; c < 16 >> k; c++)
      begin
        bus(A_TXW, 1'b1, {16'h0, 4'(c), 2'h0, d});
        getcmd(4'(c));
        bus(A_RXD, 1'b0, 32'h0);
        chk(rd, {22'h0, d});
      end
    end
    rnd = xs(rnd);
    w0 = rnd[9:0];
    bus(A_TXW, 1'b1, {22'h0, w0});
    bus(A_STAT, 1'b0, 32'h0);
    chk(rd[2], 1'b1);
    bus(A_TXW, 1'b1, {22'h0, ~w0});
    w2 = rnd[19:10];
    bus(A_TXW, 1'b1, {22'h0, w2});
    wstb(1'b0);
    bus(A_RXD, 1'b0, 32'h0);
    chk(rd, {22'h0, w0});
    repeat (60) @(posedge hclk);
    bus(A_RXD, 1'b0, 32'h0);
    chk(rd, {22'h0, w2});
    bus(8'h20, 1'b1, 32'hFFFF_FFFF);
    bus(8'h20, 1'b0, 32'h0);
    chk(rd, 32'h0);
    bus(A_TXW, 1'b0, 32'h0);
    chk(rd, 32'h0);
    jam <= 1'b1;
    repeat (30) @(posedge hclk);
    jam <= 1'b0;
    repeat (60) @(posedge hclk);
    bus(A_STAT, 1'b0, 32'h0);
    chk(rd[0], 1'b1);
    bus(A_STAT, 1'b1, 32'h1);
    bus(A_STAT, 1'b0, 32'h0);
    chk(rd[0], 1'b0);
    cascade_hold_in <= 1'b0;
    repeat (20) @(posedge hclk);
    bus(A_STAT, 1'b0, 32'h0);
    chk(rd[1], 1'b0);
    chk(warn, 1'b0);
    chk(hresp, 1'b0);
    cascade_hold_in <= 1'b1;
    repeat (180) @(posedge hclk);
    // idle 10-bit line: receive clock high 6 of 12, local clock copy half the time
    for (int i = 0; i < 120; i++)
    begin
      @(posedge hclk);
      n_rxh += (rxc === 1'b1);
      n_txh += (txc === 1'b1);
    end
    chk(n_rxh, 60);
    chk(n_txh, 60);
    conclude();
  end
endmodule // testbench
